// ### design/amc_defs.vh
// constants for the amplifier module control block
// Behaviour
// RULE_01: routing register at 0040h, resets 00h
// RULE_02: bit 3 sends channel one to resistive pin
// RULE_03: bit 2 sends channel zero to resistive pin
// RULE_04: software floats port C line first
// RULE_05: amp control: cal, gain, pos, neg fields
// RULE_06: gain code decodes to ratio or open loop
// RULE_07: cal bit ties negative input to positive
// RULE_08: first offset read uses repeater, low gain
// RULE_09: second offset read sets cal bit
// RULE_10: amp outputs to converter channels 8,9,10
// RULE_11: gain 111 selects comparator mode
// RULE_12: level bits read-only, writes ignored
// RULE_13: request pending while level equals polarity
// RULE_14: one request line per amplifier
// RULE_15: core takes request only when unmasked
// RULE_16: pending request wakes from wait and halt
// RULE_17: low-power modes leave amp settings alone
// RULE_18: readout bits enable, polarity, level, power
// RULE_19: amp two mirrors amp one layout
// RULE_20: byte registers, unused bits read zero
`ifndef AMC_DEFS_VH
`define AMC_DEFS_VH
`define AMC_ADR_W        8
`define AMC_OFF_ROUTE    8'h40
`define AMC_OFF_AMP1     8'h44
`define AMC_OFF_AMP2     8'h48
`define AMC_OFF_AMP3     8'h4C
`define AMC_OFF_IRR      8'h50
`define AMC_OFF_VREF     8'h54
`define AMC_RST_BYTE     8'h00
`define AMC_ROUTE_MASK   8'h1F
`define AMC_AMP3_MASK    8'h80
`define AMC_BIT_CH1      3
`define AMC_BIT_CH0      2
`define AMC_BIT_CAL      7
`define AMC_GAIN_HI      6
`define AMC_GAIN_LO      4
`define AMC_POS_HI       3
`define AMC_POS_LO       2
`define AMC_NEG_HI       1
`define AMC_NEG_LO       0
`define AMC_GAIN_OPEN    3'h7
`define AMC_IRR_IE1      7
`define AMC_IRR_POL1     6
`define AMC_IRR_LVL1     5
`define AMC_IRR_ON1      4
`define AMC_IRR_IE2      3
`define AMC_IRR_POL2     2
`define AMC_IRR_LVL2     1
`define AMC_IRR_ON2      0
`define AMC_ADC_CH_AMP1  4'h8
`define AMC_ADC_CH_AMP2  4'h9
`define AMC_ADC_CH_AMP3  4'hA
`endif

// ### design/amc_sync3.v
// three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module amc_sync3 (
	input  wire clk_i,
	input  wire rst_i,
	input  wire d_i,
	output reg  q_o
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			q_o  <= 1'b0;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// change counts once stages two and three agree
			if (s2_q == s3_q) begin
				q_o <= s3_q;
			end
		end
	end
endmodule

// ### design/amc_amp_ctl.v
// decode of one amplifier control byte
`timescale 1ns/1ns
`include "amc_defs.vh"
module amc_amp_ctl (
	input  wire [7:0] ctl_i,
	output wire [2:0] gain_sel_o,
	output wire [1:0] pos_sel_o,
	output wire [1:0] neg_sel_o,
	output wire       offset_cal_o,
	output wire       comparator_o
);
	assign gain_sel_o   = ctl_i[`AMC_GAIN_HI:`AMC_GAIN_LO]; // RULE_06
	assign pos_sel_o    = ctl_i[`AMC_POS_HI:`AMC_POS_LO]; // RULE_05
	assign neg_sel_o    = ctl_i[`AMC_NEG_HI:`AMC_NEG_LO]; // RULE_05
	assign offset_cal_o = ctl_i[`AMC_BIT_CAL]; // RULE_07
	// open loop: loopback network disconnected
	assign comparator_o = (gain_sel_o == `AMC_GAIN_OPEN); // RULE_11
endmodule

// ### design/amc_top.v
// amplifier module control: registers, routing, interrupt requests
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "amc_defs.vh"
module amc_top (
	input  wire       clk_i,
	input  wire       rst_i,
	// classic wishbone slave
	input  wire       wb_cyc_i,
	input  wire       wb_stb_i,
	input  wire       wb_we_i,
	input  wire [7:0] wb_adr_i,
	input  wire [3:0] wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg        wb_ack_o,
	output reg        wb_err_o,
	// pulse channels from the timer
	input  wire       pulse_channel_zero_i,
	input  wire       pulse_channel_one_i,
	output reg        pulse_channel_zero_o,
	output reg        pulse_channel_one_o,
	output reg        resistive_out_zero_o,
	output reg        resistive_out_one_o,
	// schmitt outputs of the amplifiers (asynchronous)
	input  wire       amp_one_level_i,
	input  wire       amp_two_level_i,
	// analog control
	output reg  [2:0] amp_one_gain_sel_o,
	output reg  [1:0] amp_one_pos_sel_o,
	output reg  [1:0] amp_one_neg_sel_o,
	output reg        amp_one_offset_cal_o,
	output reg        amp_one_comparator_o,
	output reg  [2:0] amp_two_gain_sel_o,
	output reg  [1:0] amp_two_pos_sel_o,
	output reg  [1:0] amp_two_neg_sel_o,
	output reg        amp_two_offset_cal_o,
	output reg        amp_two_comparator_o,
	output reg        amp_one_power_on_o,
	output reg        amp_two_power_on_o,
	output reg        standalone_power_on_o,
	output reg  [7:0] ref_level_voltage_o,
	output reg  [3:0] adc_ch_amp_one_o,
	output reg  [3:0] adc_ch_amp_two_o,
	output reg  [3:0] adc_ch_standalone_o,
	// interrupt requests and wake
	output reg        amp_one_irq_o,
	output reg        amp_two_irq_o,
	output reg        wake_o
);
	// ===========================================================
	// registers
	reg  [7:0] route_q;
	reg  [7:0] amp1_q;
	reg  [7:0] amp2_q;
	reg  [7:0] amp3_q;
	reg  [7:0] irr_q;
	reg  [7:0] vref_q;
	wire       lvl1;
	wire       lvl2;
	wire       req;
	wire       wr;
	reg        hit;
	reg  [7:0] rd_d;

	// ===========================================================
	// level inputs come from analog comparators, not this clock
	amc_sync3 u_sync1 (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (amp_one_level_i),
		.q_o   (lvl1)
	);
	amc_sync3 u_sync2 (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (amp_two_level_i),
		.q_o   (lvl2)
	);

	// ===========================================================
	// bus decode
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr  = req & wb_we_i & wb_sel_i[0] & hit;

	always @* begin
		hit  = 1'b1;
		rd_d = `AMC_RST_BYTE;
		case (wb_adr_i)
		`AMC_OFF_ROUTE: begin
			rd_d = route_q; // RULE_20
		end
		`AMC_OFF_AMP1: begin
			rd_d = amp1_q;
		end
		`AMC_OFF_AMP2: begin
			rd_d = amp2_q; // RULE_19
		end
		`AMC_OFF_AMP3: begin
			rd_d = amp3_q;
		end
		`AMC_OFF_IRR: begin
			rd_d = {irr_q[`AMC_IRR_IE1], irr_q[`AMC_IRR_POL1], lvl1,
				irr_q[`AMC_IRR_ON1], irr_q[`AMC_IRR_IE2],
				irr_q[`AMC_IRR_POL2], lvl2, irr_q[`AMC_IRR_ON2]};
			// RULE_18 RULE_12
		end
		`AMC_OFF_VREF: begin
			rd_d = vref_q;
		end
		default: begin
			hit = 1'b0;
		end
		endcase
	end

	// ===========================================================
	// register writes; low-power state has no input here by intent
	always @(posedge clk_i) begin
		if (rst_i) begin
			route_q <= `AMC_RST_BYTE; // RULE_01
			amp1_q  <= `AMC_RST_BYTE; // RULE_05
			amp2_q  <= `AMC_RST_BYTE;
			amp3_q  <= `AMC_RST_BYTE;
			irr_q   <= `AMC_RST_BYTE;
			vref_q  <= `AMC_RST_BYTE;
		end else if (wr) begin // RULE_17
			case (wb_adr_i)
			`AMC_OFF_ROUTE: begin
				route_q <= wb_dat_i[7:0] & `AMC_ROUTE_MASK; // RULE_01
			end
			`AMC_OFF_AMP1: begin
				amp1_q <= wb_dat_i[7:0]; // RULE_05
			end
			`AMC_OFF_AMP2: begin
				amp2_q <= wb_dat_i[7:0]; // RULE_19
			end
			`AMC_OFF_AMP3: begin
				amp3_q <= wb_dat_i[7:0] & `AMC_AMP3_MASK; // RULE_20
			end
			`AMC_OFF_IRR: begin
				// level bits are not stored: reads always show the pin
				irr_q[`AMC_IRR_IE1]  <= wb_dat_i[`AMC_IRR_IE1];
				irr_q[`AMC_IRR_POL1] <= wb_dat_i[`AMC_IRR_POL1];
				irr_q[`AMC_IRR_LVL1] <= 1'b0; // RULE_12
				irr_q[`AMC_IRR_ON1]  <= wb_dat_i[`AMC_IRR_ON1];
				irr_q[`AMC_IRR_IE2]  <= wb_dat_i[`AMC_IRR_IE2];
				irr_q[`AMC_IRR_POL2] <= wb_dat_i[`AMC_IRR_POL2];
				irr_q[`AMC_IRR_LVL2] <= 1'b0; // RULE_12
				irr_q[`AMC_IRR_ON2]  <= wb_dat_i[`AMC_IRR_ON2];
			end
			`AMC_OFF_VREF: begin
				vref_q <= wb_dat_i[7:0];
			end
			default: begin
				route_q <= route_q;
			end
			endcase
		end
	end

	// ===========================================================
	// bus answer: one cycle after the request, then drops
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req & hit;
			wb_err_o <= req & ~hit;
			if (req & hit & ~wb_we_i) begin
				wb_dat_o <= {24'h00_0000, rd_d};
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

	// ===========================================================
	// amplifier decode
	wire [2:0] g1;
	wire [1:0] p1;
	wire [1:0] n1;
	wire       c1;
	wire       k1;
	wire [2:0] g2;
	wire [1:0] p2;
	wire [1:0] n2;
	wire       c2;
	wire       k2;
	amc_amp_ctl u_amp1 (
		.ctl_i        (amp1_q),
		.gain_sel_o   (g1),
		.pos_sel_o    (p1),
		.neg_sel_o    (n1),
		.offset_cal_o (c1),
		.comparator_o (k1)
	);
	amc_amp_ctl u_amp2 (
		.ctl_i        (amp2_q),
		.gain_sel_o   (g2),
		.pos_sel_o    (p2),
		.neg_sel_o    (n2),
		.offset_cal_o (c2),
		.comparator_o (k2)
	);

	// ===========================================================
	// outputs, registered
	wire irq1_d = irr_q[`AMC_IRR_IE1] & (lvl1 == irr_q[`AMC_IRR_POL1]);
	wire irq2_d = irr_q[`AMC_IRR_IE2] & (lvl2 == irr_q[`AMC_IRR_POL2]);
	wire sel1   = route_q[`AMC_BIT_CH1];
	wire sel0   = route_q[`AMC_BIT_CH0];

	always @(posedge clk_i) begin
		if (rst_i) begin
			pulse_channel_zero_o  <= 1'b0;
			pulse_channel_one_o   <= 1'b0;
			resistive_out_zero_o  <= 1'b0;
			resistive_out_one_o   <= 1'b0;
			amp_one_gain_sel_o    <= 3'h0;
			amp_one_pos_sel_o     <= 2'h0;
			amp_one_neg_sel_o     <= 2'h0;
			amp_one_offset_cal_o  <= 1'b0;
			amp_one_comparator_o  <= 1'b0;
			amp_two_gain_sel_o    <= 3'h0;
			amp_two_pos_sel_o     <= 2'h0;
			amp_two_neg_sel_o     <= 2'h0;
			amp_two_offset_cal_o  <= 1'b0;
			amp_two_comparator_o  <= 1'b0;
			amp_one_power_on_o    <= 1'b0;
			amp_two_power_on_o    <= 1'b0;
			standalone_power_on_o <= 1'b0;
			ref_level_voltage_o   <= `AMC_RST_BYTE;
			adc_ch_amp_one_o      <= `AMC_ADC_CH_AMP1;
			adc_ch_amp_two_o      <= `AMC_ADC_CH_AMP2;
			adc_ch_standalone_o   <= `AMC_ADC_CH_AMP3;
			amp_one_irq_o         <= 1'b0;
			amp_two_irq_o         <= 1'b0;
			wake_o                <= 1'b0;
		end else begin
			// one-cycle pipeline on pulses; a fixed lag, no glitches
			pulse_channel_one_o  <= pulse_channel_one_i & ~sel1; // RULE_02
			resistive_out_one_o  <= pulse_channel_one_i & sel1; // RULE_02
			pulse_channel_zero_o <= pulse_channel_zero_i & ~sel0; // RULE_03
			resistive_out_zero_o <= pulse_channel_zero_i & sel0; // RULE_03
			amp_one_gain_sel_o   <= g1; // RULE_06
			amp_one_pos_sel_o    <= p1;
			amp_one_neg_sel_o    <= n1;
			amp_one_offset_cal_o <= c1; // RULE_07
			amp_one_comparator_o <= k1; // RULE_11
			amp_two_gain_sel_o   <= g2; // RULE_19
			amp_two_pos_sel_o    <= p2;
			amp_two_neg_sel_o    <= n2;
			amp_two_offset_cal_o <= c2; // RULE_07
			amp_two_comparator_o <= k2; // RULE_11
			amp_one_power_on_o    <= irr_q[`AMC_IRR_ON1]; // RULE_17
			amp_two_power_on_o    <= irr_q[`AMC_IRR_ON2]; // RULE_17
			standalone_power_on_o <= amp3_q[`AMC_BIT_CAL];
			ref_level_voltage_o  <= vref_q;
			adc_ch_amp_one_o     <= `AMC_ADC_CH_AMP1; // RULE_10
			adc_ch_amp_two_o     <= `AMC_ADC_CH_AMP2; // RULE_10
			adc_ch_standalone_o  <= `AMC_ADC_CH_AMP3; // RULE_10
			// level request, no latch: it follows the condition
			amp_one_irq_o <= irq1_d; // RULE_13 RULE_14
			amp_two_irq_o <= irq2_d; // RULE_13 RULE_14
			wake_o        <= irq1_d | irq2_d; // RULE_16
		end
	end
endmodule

// ### dv/amc_top_chk.sv
// assertion checker bound to the amplifier control top
`timescale 1ns/1ns
`include "amc_defs.vh"
module amc_top_chk (
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire [7:0]  wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        wb_err_o,
	input wire        pulse_channel_zero_i,
	input wire        pulse_channel_one_i,
	input wire        pulse_channel_zero_o,
	input wire        pulse_channel_one_o,
	input wire        resistive_out_zero_o,
	input wire        resistive_out_one_o,
	input wire [2:0]  amp_one_gain_sel_o,
	input wire        amp_one_comparator_o,
	input wire [2:0]  amp_two_gain_sel_o,
	input wire        amp_two_comparator_o,
	input wire [3:0]  adc_ch_amp_one_o,
	input wire [3:0]  adc_ch_amp_two_o,
	input wire [3:0]  adc_ch_standalone_o,
	input wire        amp_one_irq_o,
	input wire        amp_two_irq_o,
	input wire        wake_o
);
	// ======================================================
	// helpers
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire mapped = wb_adr_i == `AMC_OFF_ROUTE || wb_adr_i == `AMC_OFF_AMP1 ||
		wb_adr_i == `AMC_OFF_AMP2 || wb_adr_i == `AMC_OFF_AMP3 ||
		wb_adr_i == `AMC_OFF_IRR || wb_adr_i == `AMC_OFF_VREF;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ======================================================
	// properties
	property p_adc;
		adc_ch_amp_one_o == 4'h8 && adc_ch_amp_two_o == 4'h9 &&
		adc_ch_standalone_o == 4'hA;
	endproperty
	a_adc: assert property (p_adc) else $error("adc channel wrong");
	// the pulse goes to exactly one pin, one cycle late, whatever the route
	property p_route0;
		!$past(rst_i) |-> !(pulse_channel_zero_o && resistive_out_zero_o) &&
		(pulse_channel_zero_o || resistive_out_zero_o) == $past(pulse_channel_zero_i);
	endproperty
	a_route0: assert property (p_route0) else $error("chan zero lost");
	property p_route1;
		!$past(rst_i) |-> !(pulse_channel_one_o && resistive_out_one_o) &&
		(pulse_channel_one_o || resistive_out_one_o) == $past(pulse_channel_one_i);
	endproperty
	a_route1: assert property (p_route1) else $error("chan one lost");
	property p_cmp1;
		amp_one_comparator_o == (amp_one_gain_sel_o == 3'h7);
	endproperty
	a_cmp1: assert property (p_cmp1) else $error("amp one mode");
	property p_cmp2;
		amp_two_comparator_o == (amp_two_gain_sel_o == 3'h7);
	endproperty
	a_cmp2: assert property (p_cmp2) else $error("amp two mode");
	property p_wake_on;
		$rose(amp_one_irq_o) || $rose(amp_two_irq_o) |-> ##[0:1] wake_o;
	endproperty
	a_wake_on: assert property (p_wake_on) else $error("no wake");
	property p_wake_off;
		!(amp_one_irq_o || amp_two_irq_o) [*2] |-> !wake_o;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("stray wake");
	property p_take;
		take |=> (wb_ack_o != wb_err_o) ##1 !wb_ack_o && !wb_err_o;
	endproperty
	a_take: assert property (p_take) else $error("bad answer");
	property p_err;
		take && !mapped |=> wb_err_o && wb_dat_o == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("unmapped not refused");
	property p_rdhi;
		wb_dat_o[31:8] == 24'h0;
	endproperty
	a_rdhi: assert property (p_rdhi) else $error("upper bytes set");
endmodule

bind amc_top amc_top_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.pulse_channel_zero_i(pulse_channel_zero_i),
	.pulse_channel_one_i(pulse_channel_one_i),
	.pulse_channel_zero_o(pulse_channel_zero_o),
	.pulse_channel_one_o(pulse_channel_one_o),
	.resistive_out_zero_o(resistive_out_zero_o),
	.resistive_out_one_o(resistive_out_one_o),
	.amp_one_gain_sel_o(amp_one_gain_sel_o),
	.amp_one_comparator_o(amp_one_comparator_o),
	.amp_two_gain_sel_o(amp_two_gain_sel_o),
	.amp_two_comparator_o(amp_two_comparator_o),
	.adc_ch_amp_one_o(adc_ch_amp_one_o), .adc_ch_amp_two_o(adc_ch_amp_two_o),
	.adc_ch_standalone_o(adc_ch_standalone_o), .amp_one_irq_o(amp_one_irq_o),
	.amp_two_irq_o(amp_two_irq_o), .wake_o(wake_o));

// ### dv/amc_top_test.sv
// self-checking bench for the amplifier control block
`timescale 1ns/1ns
`include "amc_defs.vh"
module amc_top_test;
	// ======================================================
	// signals
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        pz = 1'b0, po = 1'b0, l1 = 1'b0, l2 = 1'b0, hold = 1'b0;
	logic [7:0]  adr = 8'h00, v, w;
	logic [3:0]  sel = 4'h0, lane = 4'h1;
	logic [31:0] dat = 32'h0;
	logic [9:0]  e_cur;
	logic [9:0]  exp_q [$];
	logic        x1, x2;
	int          fail_count = 0, n_compared = 0, cyc_cnt = 0;
	wire [31:0]  dat_o;
	wire         ack, err, pz_o, po_o, rz_o, ro_o, cal1, cal2, cmp1, cmp2;
	wire         on1, on2, on3, irq1, irq2, wake;
	wire [2:0]   g1, g2;
	wire [1:0]   ps1, ns1, ps2, ns2;
	wire [7:0]   vref;
	always #25 clk_i = ~clk_i;
	amc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
		.pulse_channel_zero_i(pz), .pulse_channel_one_i(po),
		.pulse_channel_zero_o(pz_o), .pulse_channel_one_o(po_o),
		.resistive_out_zero_o(rz_o), .resistive_out_one_o(ro_o),
		.amp_one_level_i(l1), .amp_two_level_i(l2), .amp_one_gain_sel_o(g1),
		.amp_one_pos_sel_o(ps1), .amp_one_neg_sel_o(ns1),
		.amp_one_offset_cal_o(cal1), .amp_one_comparator_o(cmp1),
		.amp_two_gain_sel_o(g2), .amp_two_pos_sel_o(ps2),
		.amp_two_neg_sel_o(ns2), .amp_two_offset_cal_o(cal2),
		.amp_two_comparator_o(cmp2), .amp_one_power_on_o(on1),
		.amp_two_power_on_o(on2), .standalone_power_on_o(on3),
		.ref_level_voltage_o(vref), .adc_ch_amp_one_o(), .adc_ch_amp_two_o(),
		.adc_ch_standalone_o(), .amp_one_irq_o(irq1), .amp_two_irq_o(irq2),
		.wake_o(wake));
	// ======================================================
	// tasks
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		n_compared++;
		if (g !== x) begin
			fail_count++;
			$display("Error %0t: got %h want %h", $time, g, x);
		end
	endtask
	// e: bit 8 expected refusal, bits 7:0 expected read byte
	task automatic wb(input logic w_, input logic [7:0] a, input logic [7:0] d,
		input logic [8:0] e);
		@(posedge clk_i);
		exp_q.push_back({~w_, e});
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w_;
		adr <= a;
		sel <= lane;
		dat <= {24'h0, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && err !== 1'b1)
			@(posedge clk_i);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task summarize;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ======================================================
	// monitor, random pulses, timeout
	always @(posedge clk_i) begin
		if (ack === 1'b1 || err === 1'b1) begin
			e_cur = exp_q.size() > 0 ? exp_q.pop_front() : 10'h3FF;
			chk({7'h0, err}, {7'h0, e_cur[8]});
			if (e_cur[9])
				chk(dat_o[7:0], e_cur[7:0]);
		end
	end
	always @(posedge clk_i) begin
		if (!hold)
			{pz, po} <= 2'($urandom);
	end
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			fail_count++;
			summarize();
		end
	end
	// ======================================================
	// main sequence
	initial begin
		v = 8'($urandom(32'h1a86c5ce));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `AMC_OFF_ROUTE, 8'h00, 9'h000);
		wb(1'b0, `AMC_OFF_AMP1, 8'h00, 9'h000);
		wb(1'b0, `AMC_OFF_AMP2, 8'h00, 9'h000);
		wb(1'b0, `AMC_OFF_IRR, 8'h00, 9'h000);
		wb(1'b0, 8'h41, 8'h00, 9'h100);
		wb(1'b1, 8'h7C, 8'hFF, 9'h100);
		wb(1'b1, `AMC_OFF_ROUTE, 8'hFF, 9'h000);
		wb(1'b0, `AMC_OFF_ROUTE, 8'h00, 9'h01F);
		// write with byte lane 0 off: answered, register unchanged
		lane <= 4'h0;
		wb(1'b1, `AMC_OFF_ROUTE, 8'h00, 9'h000);
		lane <= 4'h1;
		wb(1'b0, `AMC_OFF_ROUTE, 8'h00, 9'h01F);
		hold <= 1'b1;
		for (int r = 0; r < 4; r++) begin
			// port C lines count as floating before any route bit is set
			wb(1'b1, `AMC_OFF_ROUTE, 8'(r << 2), 9'h000);
			pz <= 1'b1;
			po <= 1'b1;
			repeat (2) @(posedge clk_i);
			#1;
			chk({6'h0, pz_o, rz_o}, {6'h0, ~r[0], r[0]});
			chk({6'h0, po_o, ro_o}, {6'h0, ~r[1], r[1]});
		end
		hold <= 1'b0;
		// every gain code on both amplifiers, other fields random
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			v[6:4] = 3'(i);
			wb(1'b1, `AMC_OFF_AMP1, v, 9'h000);
			wb(1'b1, `AMC_OFF_AMP2, ~v, 9'h000);
			wb(1'b0, `AMC_OFF_AMP1, 8'h00, {1'b0, v});
			wb(1'b0, `AMC_OFF_AMP2, 8'h00, {1'b0, ~v});
			#1;
			chk({cal1, g1, ps1, ns1}, v);
			chk({cal2, g2, ps2, ns2}, ~v);
			chk({6'h0, cmp1, cmp2}, {6'h0, i == 7, i == 0});
		end
		// offset sequence: repeater at lowest gain, then cal bit with gain
		wb(1'b1, `AMC_OFF_AMP1, 8'h01, 9'h000);
		#1;
		chk({cal1, g1, ps1, ns1}, 8'h01);
		wb(1'b1, `AMC_OFF_AMP1, 8'hC1, 9'h000);
		#1;
		chk({cal1, g1, ps1, ns1}, 8'hC1);
		chk({7'h0, cmp1}, 8'h00);
		wb(1'b1, `AMC_OFF_AMP3, 8'hFF, 9'h000);
		wb(1'b0, `AMC_OFF_AMP3, 8'h00, 9'h080);
		wb(1'b1, `AMC_OFF_VREF, v, 9'h000);
		wb(1'b0, `AMC_OFF_VREF, 8'h00, {1'b0, v});
		#1;
		chk({7'h0, on3}, 8'h01);
		chk(vref, v);
		// level bits are written as 1 and must read back the pins instead
		for (int k = 0; k < 16; k++) begin
			w = {k[0], k[1], 2'h3, k[0], ~k[1], 2'h3};
			x1 = k[0] && (k[2] == k[1]);
			x2 = k[0] && (k[3] == ~k[1]);
			@(posedge clk_i);
			l1 <= k[2];
			l2 <= k[3];
			wb(1'b1, `AMC_OFF_IRR, w, 9'h000);
			repeat (6) @(posedge clk_i);
			wb(1'b0, `AMC_OFF_IRR, 8'h00,
				{1'b0, w[7:6], k[2], 1'b1, w[3:2], k[3], 1'b1});
			#1;
			chk({5'h0, irq1, irq2, wake}, {5'h0, x1, x2, x1 | x2});
			chk({6'h0, on1, on2}, 8'h03);
			// a masked core may take it late: the request must stand
			repeat (3) @(posedge clk_i);
			#1;
			chk({5'h0, irq1, irq2, wake}, {5'h0, x1, x2, x1 | x2});
		end
		repeat (2) @(posedge clk_i);
		chk(8'(exp_q.size()), 8'h00);
		summarize();
	end
endmodule
